// *** shared/smr_regs.svh ***
// Purpose: register indexes, field positions, reset values of the sync receiver
// Assumes: byte address on the bus is four times the register index
// Notes: definitions only
`ifndef SMR_REGS_SVH
`define SMR_REGS_SVH

`define SMR_IDX_INTCTL 8'h0B
`define SMR_IDX_PFLAGS 8'h0C
`define SMR_IDX_RXSTAT 8'h18
`define SMR_IDX_TXBUF 8'h19
`define SMR_IDX_RXBUF 8'h1A
`define SMR_IDX_PENABL 8'h8C
`define SMR_IDX_TXSTAT 8'h98
`define SMR_IDX_BAUD 8'h99

`define SMR_BIT_GIE 7
`define SMR_BIT_PERIPHERAL_IRQ_ENABLE 6
`define SMR_BIT_RXFLAG 5
`define SMR_BIT_RXIE 5
`define SMR_BIT_SERIAL_PORT_ENABLE 7
`define SMR_BIT_RX9 6
`define SMR_BIT_SINGLE_RECEIVE_ENABLE 5
`define SMR_BIT_CONTINUOUS_RECEIVE_ENABLE 4
`define SMR_BIT_OVERRUN_ERROR 1
`define SMR_BIT_CLOCK_MASTER_SELECT 7
`define SMR_BIT_TRANSMIT_ENABLE 5
`define SMR_BIT_SYNC 4

`define SMR_RST_INTCTL 8'h00
`define SMR_RST_PENABL 8'h00
`define SMR_RST_TXSTAT 8'h02
`define SMR_RST_TXBUF 8'h00
`define SMR_RST_BAUD 8'h00
`define SMR_TXSTAT_WMASK 8'hF5
`define SMR_LAST_BIT8 4'h7
`define SMR_LAST_BIT9 4'h8
`define SMR_FIFO_FULL 2'h2

`endif

// *** shared/smr_pkg.sv ***
// Purpose: types of the sync master serial receiver
// Assumes: nothing
// Notes: state of the top module is one packed struct
package smr_pkg;

  typedef enum logic [1:0] {
    SMR_ST_IDLE = 2'b01,
    SMR_ST_SHIFT = 2'b10
  } smr_rx_state_t;

  typedef struct packed {
    logic read;
    logic write;
    logic [9:0] address;
    logic [31:0] writedata;
  } smr_av_req_t;

  typedef struct packed {
    smr_rx_state_t st;
    logic din1;
    logic din2;
    logic [7:0] intctl;
    logic [7:0] penabl;
    logic [7:0] txstat;
    logic [7:0] txbuf;
    logic [7:0] baud;
    logic serial_port_enable;
    logic rx9;
    logic single_receive_enable;
    logic continuous_receive_enable;
    logic overrun_error;
    logic [7:0] cnt;
    logic sck;
    logic sck_oe;
    logic [3:0] bitcnt;
    logic [8:0] sr;
    logic [1:0][8:0] fifo;
    logic rd_ptr;
    logic [1:0] count;
    logic waitreq;
    logic [31:0] rdata;
    logic irq;
    logic dt_oe;
  } smr_state_t;

endpackage

// *** verilog/smr_rx_top.sv ***
// Purpose: synchronous master receive path with two-deep receive fifo
// Assumes: registers reached over Avalon-MM with waitrequest, byte addressing
// Notes: transmit shifter not present; its register bits are only stored
// Operation
// - either receive enable starts reception with serial port enabled in sync master mode
// - sample data line on shift clock falling edge
// - single enable receives exactly one word
// - continuous enable receives until software clears it
// - both enables set behaves as continuous
// - finished word moves to fifo when room
// - transfer sets receive flag; enable gates interrupt
// - receive flag read-only, cleared when fifo empty
// - fifo holds two words in order
// - full fifo at word end sets overrun, drops word
// - overrun cleared only by clearing continuous enable
// - overrun blocks every transfer into fifo
// - ninth bit travels with its word through fifo
// - nine-bit select receives nine bits per word
// - interrupt needs global and peripheral enables
// - unimplemented register bits read zero
// - sync mode and clock master bits in transmit status
// - baud generator held reset while all enables clear
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ns
`include "smr_regs.svh"

module smr_rx_top (
  input wire logic CORE_CLK_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  input wire smr_pkg::smr_av_req_t AV_REQ_IN,
  output logic [31:0] AV_READDATA_OUT,
  output logic AV_WAITREQUEST_OUT,
  output logic SCK_OUT,
  output logic SCK_OE_OUT,
  input wire logic DATA_IN,
  output logic DATA_OUT,
  output logic DATA_OE_OUT,
  output logic IRQ_OUT
);
  import smr_pkg::*;

  smr_state_t s_reg;
  smr_state_t s_next;
  logic [7:0] idx;
  logic bus_rd_go;
  logic bus_wr_go;
  logic brg_run;
  logic rx_go;
  logic sck_fall;
  logic word_done;
  logic push;
  logic pop;
  logic [8:0] sr_new;
  logic [8:0] word;
  logic [3:0] last_bit;
  logic [7:0] rd_value;
  logic [7:0] wdata;
  logic [8:0] head;

  always_comb begin
    s_next = s_reg;
    idx = AV_REQ_IN.address[9:2];
    wdata = AV_REQ_IN.writedata[7:0];
    push = 1'b0;
    pop = 1'b0;
    word_done = 1'b0;
    sck_fall = 1'b0;
    word = 9'h000;
    sr_new = {s_reg.din2, s_reg.sr[8:1]};
    last_bit = s_reg.rx9 ? `SMR_LAST_BIT9 : `SMR_LAST_BIT8;
    // pin input passes two flops; only the second is read
    s_next.din1 = DATA_IN;
    s_next.din2 = s_reg.din1;

    // read mux; unmapped and unimplemented bits answer zero
    case (idx)
      `SMR_IDX_INTCTL: rd_value = s_reg.intctl;
      `SMR_IDX_PFLAGS: rd_value = {2'h0, s_reg.count != 2'h0, 5'h00};
      `SMR_IDX_RXSTAT: rd_value = {s_reg.serial_port_enable, s_reg.rx9, s_reg.single_receive_enable, s_reg.continuous_receive_enable, 2'h0,
        s_reg.overrun_error, (s_reg.count != 2'h0) & s_reg.fifo[s_reg.rd_ptr][8]};
      `SMR_IDX_TXBUF: rd_value = s_reg.txbuf;
      `SMR_IDX_RXBUF: rd_value = s_reg.fifo[s_reg.rd_ptr][7:0];
      `SMR_IDX_PENABL: rd_value = s_reg.penabl;
      `SMR_IDX_TXSTAT: rd_value = s_reg.txstat;
      `SMR_IDX_BAUD: rd_value = s_reg.baud;
      default: rd_value = 8'h00;
    endcase

    // bus: request seen with waitrequest high is answered next edge;
    // writes commit at the edge where the master sees waitrequest low
    bus_rd_go = AV_REQ_IN.read & s_reg.waitreq;
    bus_wr_go = AV_REQ_IN.write & ~s_reg.waitreq;
    if (s_reg.waitreq && (AV_REQ_IN.read || AV_REQ_IN.write)) begin
      s_next.waitreq = 1'b0;
      s_next.rdata = {24'h000000, AV_REQ_IN.read ? rd_value : 8'h00};
    end else begin
      s_next.waitreq = 1'b1;
    end
    // pop at the answer edge so the word returned is the word removed
    if (bus_rd_go && idx == `SMR_IDX_RXBUF && s_reg.count != 2'h0) begin
      pop = 1'b1;
    end

    // shift clock generator
    brg_run = s_reg.txstat[`SMR_BIT_TRANSMIT_ENABLE] | s_reg.continuous_receive_enable | s_reg.single_receive_enable;
    rx_go = brg_run & s_reg.serial_port_enable & s_reg.txstat[`SMR_BIT_SYNC] &
      s_reg.txstat[`SMR_BIT_CLOCK_MASTER_SELECT] & (s_reg.continuous_receive_enable | s_reg.single_receive_enable);
    s_next.sck_oe = s_reg.serial_port_enable & s_reg.txstat[`SMR_BIT_SYNC] & s_reg.txstat[`SMR_BIT_CLOCK_MASTER_SELECT];
    case (s_reg.st)
      SMR_ST_IDLE: begin
        s_next.cnt = 8'h00;
        s_next.sck = 1'b0;
        s_next.bitcnt = 4'h0;
        if (rx_go) begin
          s_next.st = SMR_ST_SHIFT;
          s_next.dt_oe = 1'b0;
        end
      end
      SMR_ST_SHIFT: begin
        if (!rx_go) begin
          // a dropped enable abandons the partial word
          s_next.st = SMR_ST_IDLE;
          s_next.cnt = 8'h00;
          s_next.sck = 1'b0;
          s_next.bitcnt = 4'h0;
        end else if (s_reg.cnt == s_reg.baud) begin
          s_next.cnt = 8'h00;
          s_next.sck = ~s_reg.sck;
          sck_fall = s_reg.sck;
        end else begin
          s_next.cnt = s_reg.cnt + 8'h01;
        end
        if (sck_fall) begin
          s_next.sr = sr_new;
          if (s_reg.bitcnt == last_bit) begin
            word_done = 1'b1;
            s_next.bitcnt = 4'h0;
          end else begin
            s_next.bitcnt = s_reg.bitcnt + 4'h1;
          end
        end
      end
      default: begin
        s_next.st = SMR_ST_IDLE;
      end
    endcase

    if (word_done) begin
      word = s_reg.rx9 ? sr_new : {1'b0, sr_new[8:1]};
      if (s_reg.overrun_error) begin
        push = 1'b0;
      end else if (s_reg.count == `SMR_FIFO_FULL) begin
        s_next.overrun_error = 1'b1;
      end else begin
        push = 1'b1;
      end
      if (s_reg.single_receive_enable && !s_reg.continuous_receive_enable) begin
        // single word finished: hardware drops its own enable
        s_next.single_receive_enable = 1'b0;
        s_next.st = SMR_ST_IDLE;
        s_next.dt_oe = 1'b0;
      end
    end

    if (push) begin
      s_next.fifo[s_reg.rd_ptr ^ s_reg.count[0]] = word;
    end
    if (pop) begin
      s_next.rd_ptr = ~s_reg.rd_ptr;
    end
    if (push && !pop) begin
      s_next.count = s_reg.count + 2'h1;
    end else if (pop && !push) begin
      s_next.count = s_reg.count - 2'h1;
    end

    // software writes; a write in the same cycle wins over the hardware clear
    if (bus_wr_go) begin
      case (idx)
        `SMR_IDX_INTCTL: s_next.intctl = wdata;
        `SMR_IDX_RXSTAT: begin
          s_next.serial_port_enable = wdata[`SMR_BIT_SERIAL_PORT_ENABLE];
          s_next.rx9 = wdata[`SMR_BIT_RX9];
          s_next.single_receive_enable = wdata[`SMR_BIT_SINGLE_RECEIVE_ENABLE];
          s_next.continuous_receive_enable = wdata[`SMR_BIT_CONTINUOUS_RECEIVE_ENABLE];
        end
        `SMR_IDX_TXBUF: s_next.txbuf = wdata;
        `SMR_IDX_PENABL: s_next.penabl = wdata;
        `SMR_IDX_TXSTAT: s_next.txstat = (wdata & `SMR_TXSTAT_WMASK) |
          (s_reg.txstat & ~`SMR_TXSTAT_WMASK);
        `SMR_IDX_BAUD: s_next.baud = wdata;
        default: s_next.baud = s_reg.baud;
      endcase
    end
    // overrun only falls with the continuous enable; a new overrun wins
    if (!s_next.continuous_receive_enable && !(word_done && !s_reg.overrun_error &&
        s_reg.count == `SMR_FIFO_FULL)) begin
      s_next.overrun_error = 1'b0;
    end

    s_next.irq = s_reg.intctl[`SMR_BIT_GIE] & s_reg.intctl[`SMR_BIT_PERIPHERAL_IRQ_ENABLE] &
      s_reg.penabl[`SMR_BIT_RXIE] & (s_reg.count != 2'h0);
  end

  always_ff @(posedge CORE_CLK_IN) begin
    if (SRST_IN) begin
      s_reg <= '0;
      s_reg.st <= SMR_ST_IDLE;
      s_reg.intctl <= `SMR_RST_INTCTL;
      s_reg.penabl <= `SMR_RST_PENABL;
      s_reg.txstat <= `SMR_RST_TXSTAT;
      s_reg.txbuf <= `SMR_RST_TXBUF;
      s_reg.baud <= `SMR_RST_BAUD;
      s_reg.waitreq <= 1'b1;
    end else if (CE_IN) begin
      s_reg <= s_next;
    end
  end

  assign AV_READDATA_OUT = s_reg.rdata;
  assign AV_WAITREQUEST_OUT = s_reg.waitreq;
  assign SCK_OUT = s_reg.sck;
  assign SCK_OE_OUT = s_reg.sck_oe;
  assign DATA_OUT = 1'b0;
  assign DATA_OE_OUT = s_reg.dt_oe;
  assign IRQ_OUT = s_reg.irq;
  assign head = s_reg.fifo[s_reg.rd_ptr];

  default clocking smr_cb @(posedge CORE_CLK_IN);
  endclocking
  default disable iff (SRST_IN);

  sample_on_fall_a: assert property (CE_IN && sck_fall |=>
    !s_reg.sck && s_reg.sr[8] == $past(s_reg.din2))
    else $error("shift register not loaded on falling shift clock");
  fifo_depth_a: assert property (s_reg.count <= `SMR_FIFO_FULL)
    else $error("receive fifo holds more than two words");
  overrun_set_a: assert property (CE_IN && word_done && s_reg.count == 2'h2 &&
    s_next.continuous_receive_enable |=> s_reg.overrun_error && s_reg.count == ($past(pop) ? 2'h1 : 2'h2))
    else $error("overrun not flagged or word not dropped");
  overrun_blocks_a: assert property (CE_IN && s_reg.overrun_error && !pop |=>
    s_reg.count == $past(s_reg.count))
    else $error("word entered fifo during overrun");
  overrun_clear_a: assert property (CE_IN && !s_next.continuous_receive_enable && !word_done |=>
    !s_reg.overrun_error)
    else $error("overrun survived clearing of continuous enable");
  single_stop_a: assert property (CE_IN && word_done && s_reg.single_receive_enable &&
    !s_reg.continuous_receive_enable && !bus_wr_go |=> !s_reg.single_receive_enable ##1 s_reg.st == SMR_ST_IDLE)
    else $error("single word reception did not stop");
  brg_hold_a: assert property (CE_IN && !brg_run |=>
    s_reg.cnt == 8'h00 && !s_reg.sck)
    else $error("baud generator ran with all enables clear");
  irq_gate_a: assert property (IRQ_OUT |-> $past(s_reg.intctl[`SMR_BIT_GIE]) &&
    $past(s_reg.intctl[`SMR_BIT_PERIPHERAL_IRQ_ENABLE]) && $past(s_reg.penabl[`SMR_BIT_RXIE]))
    else $error("interrupt raised without its enables");
  word_width_a: assert property (CE_IN && word_done |->
    s_reg.bitcnt == (s_reg.rx9 ? 4'h8 : 4'h7))
    else $error("word length does not follow nine-bit select");
  bus_answer_a: assert property (CE_IN && AV_REQ_IN.read && s_reg.waitreq |=>
    !AV_WAITREQUEST_OUT ##1 AV_WAITREQUEST_OUT)
    else $error("register read not answered in one cycle");

  // bus views of the flag, status and fifo head
  flag_read_a: assert property (CE_IN && bus_rd_go && idx == `SMR_IDX_PFLAGS |=>
    AV_READDATA_OUT[5] == ($past(s_reg.count) != 2'h0) &&
    AV_READDATA_OUT[7:6] == 2'h0 && AV_READDATA_OUT[4:0] == 5'h00)
    else $error("receive flag read does not follow fifo fill");

  status_bits_a: assert property (CE_IN && bus_rd_go && idx == `SMR_IDX_RXSTAT |=>
    AV_READDATA_OUT[1] == $past(s_reg.overrun_error) && AV_READDATA_OUT[3:2] == 2'h0)
    else $error("status read misplaces overrun or unused bits");

  ninth_view_a: assert property (CE_IN && bus_rd_go && idx == `SMR_IDX_RXSTAT |=>
    AV_READDATA_OUT[0] == ($past(s_reg.count) != 2'h0 && $past(head[8])))
    else $error("ninth bit view does not follow fifo head");

  fifo_order_a: assert property (CE_IN && pop |=>
    AV_READDATA_OUT[7:0] == $past(head[7:0]) && s_reg.rd_ptr != $past(s_reg.rd_ptr))
    else $error("buffer read did not return and drop the oldest word");

  flag_clear_a: assert property (CE_IN && pop && s_reg.count == 2'h1 &&
    !push |=> s_reg.count == 2'h0)
    else $error("receive flag survived the last buffer read");

  push_room_a: assert property (CE_IN && push |-> s_reg.count != `SMR_FIFO_FULL)
    else $error("word pushed into a full fifo");

  word_push_a: assert property (CE_IN && word_done && !s_reg.overrun_error &&
    s_reg.count != `SMR_FIFO_FULL |-> push)
    else $error("finished word not moved into fifo with room");

  overrun_drop_a: assert property (CE_IN && word_done &&
    s_reg.count == `SMR_FIFO_FULL |-> !push)
    else $error("third word entered a full fifo");

  overrun_no_push_a: assert property (CE_IN && s_reg.overrun_error |-> !push)
    else $error("word pushed while overrun set");

  overrun_hold_a: assert property (CE_IN && s_reg.overrun_error && s_next.continuous_receive_enable |=> s_reg.overrun_error)
    else $error("overrun cleared while continuous enable stayed set");

  rx_start_a: assert property (CE_IN && s_reg.st == SMR_ST_IDLE && rx_go |=>
    s_reg.st == SMR_ST_SHIFT)
    else $error("reception did not start on a receive enable");

  idle_stop_a: assert property (CE_IN && !s_reg.continuous_receive_enable && !s_reg.single_receive_enable |=>
    s_reg.st == SMR_ST_IDLE)
    else $error("reception went on with both enables clear");

  cont_keeps_a: assert property (CE_IN && word_done && s_reg.continuous_receive_enable && !bus_wr_go |=>
    s_reg.single_receive_enable == $past(s_reg.single_receive_enable) && s_reg.st == SMR_ST_SHIFT)
    else $error("continuous reception stopped after a word");

  shift_hold_a: assert property (CE_IN && !sck_fall |=> s_reg.sr == $past(s_reg.sr))
    else $error("shift register moved off a falling shift clock");

  sck_steady_a: assert property (CE_IN && s_reg.st == SMR_ST_SHIFT && rx_go &&
    s_reg.cnt != s_reg.baud |=> s_reg.sck == $past(s_reg.sck))
    else $error("shift clock toggled before the divider ran out");

  irq_follows_a: assert property (CE_IN && s_reg.count != 2'h0 &&
    s_reg.intctl[`SMR_BIT_GIE] && s_reg.intctl[`SMR_BIT_PERIPHERAL_IRQ_ENABLE] &&
    s_reg.penabl[`SMR_BIT_RXIE] |=> IRQ_OUT)
    else $error("interrupt missing with flag and enables set");

  tx_fixed_a: assert property (!s_reg.txstat[3] && s_reg.txstat[1])
    else $error("read-only transmit status bits changed");

  clock_pin_a: assert property (SCK_OE_OUT |-> $past(s_reg.serial_port_enable) &&
    $past(s_reg.txstat[`SMR_BIT_SYNC]) && $past(s_reg.txstat[`SMR_BIT_CLOCK_MASTER_SELECT]))
    else $error("shift clock driven outside sync master mode");

  single_quiet_a: assert property (CE_IN && word_done && s_reg.single_receive_enable &&
    !s_reg.continuous_receive_enable |=> !DATA_OE_OUT && !SCK_OUT)
    else $error("single word end left data driven or clock high");

endmodule

// *** tb/smr_slave_model.sv ***
// Purpose: serial slave that feeds queued words to the receiver
// Assumes: slave changes data on the rising shift clock edge, lsb first
// Notes: the bench queues words and may reset idx after an abandoned word
`timescale 1ns/1ns
module smr_slave_model (
  input wire logic clk_in,
  input wire logic sck_in,
  input wire logic sck_oe_in,
  input wire logic nine_in,
  output logic data_out
);
  logic [8:0] words[$];
  logic [8:0] cur;
  logic sck_d;
  int idx;
  initial begin
    data_out = 1'b0;
    sck_d = 1'b0;
    cur = 9'h155;
    idx = 0;
  end
  always @(posedge clk_in) begin
    sck_d <= sck_in;
    if (!sck_oe_in) begin
      // no pull on the line, so it never keeps a stale level
      data_out <= ~data_out;
    end else if (sck_in && !sck_d) begin
      if (idx == 0 && words.size() != 0) begin
        cur = words.pop_front();
      end
      data_out <= cur[idx];
      idx = (idx == (nine_in ? 8 : 7)) ? 0 : idx + 1;
    end
  end
endmodule

// *** tb/smr_rx_top_bench.sv ***
// Purpose: self-checking bench of the sync master receiver
// Assumes: one wait state per bus access, link period 64 ns (divider 7)
// Notes: polling reads stand in for the interrupt line where timing is loose
`timescale 1ns/1ns
`include "smr_regs.svh"
module smr_rx_top_bench;
  import smr_pkg::*;
  logic clk, srst, din, sck, sck_oe, doe, irq, wreq, nine, ce, dout, hold;
  logic [31:0] rdata;
  smr_av_req_t req;
  int mismatches, tests_run;
  logic [8:0] w[4];
  localparam logic [7:0] rs = `SMR_IDX_RXSTAT;
  localparam logic [7:0] rb = `SMR_IDX_RXBUF;
  localparam logic [7:0] pf = `SMR_IDX_PFLAGS;
  logic [7:0] ridx[8] = '{8'h0B, 8'h0C, 8'h18, 8'h19, 8'h1A, 8'h8C, 8'h98, 8'h99};
  logic [7:0] rrst[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00};
  logic [7:0] ictl[4] = '{8'h00, 8'h40, 8'h80, 8'hC0};

  smr_rx_top dut (.CORE_CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .AV_REQ_IN(req),
    .AV_READDATA_OUT(rdata), .AV_WAITREQUEST_OUT(wreq), .SCK_OUT(sck), .SCK_OE_OUT(sck_oe),
    .DATA_IN(din), .DATA_OUT(dout), .DATA_OE_OUT(doe), .IRQ_OUT(irq));
  smr_slave_model partner (.clk_in(clk), .sck_in(sck), .sck_oe_in(sck_oe), .nine_in(nine),
    .data_out(din));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic bus(input logic is_wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{!is_wr, is_wr, {a, 2'b00}, {24'h0, d}};
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    r = rdata[7:0];
    req <= '0;
    if (n >= 40) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] t;
    bus(1'b1, a, d, t);
  endtask
  task automatic rc(input string what, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] t;
    bus(1'b0, a, 8'h00, t);
    chk(what, {24'h0, t}, {24'h0, exp});
  endtask
  task automatic poll(input logic [7:0] a, input int b);
    logic [7:0] t;
    int n;
    n = 0;
    t = 8'h00;
    while (t[b] !== 1'b1 && n < 400) begin
      bus(1'b0, a, 8'h00, t);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      tally_and_finish();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    srst = 1'b1;
    req = '0;
    ce = 1'b1;
    nine = 1'b0;
    mismatches = 0;
    tests_run = 0;
    void'($urandom(32'h46f6));
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    foreach (ridx[i]) rc("reset value", ridx[i], rrst[i]);
    wr(8'h98, 8'h08);
    rc("tx status fixed bits", 8'h98, 8'h02);
    wr(rs, 8'h0A);
    rc("rx status fixed bits", rs, 8'h00);
    wr(8'h20, 8'h5A);
    rc("unmapped", 8'h20, 8'h00);
    wr(pf, 8'hFF);
    rc("flag read-only", pf, 8'h00);
    $display("test registers done");
    // setup in the safe order, enables last
    wr(`SMR_IDX_BAUD, 8'h07);
    wr(8'h98, 8'h90);
    wr(rs, 8'h80);
    wr(`SMR_IDX_PENABL, 8'h20);
    wr(`SMR_IDX_INTCTL, 8'hC0);
    chk("clock still", {31'h0, sck}, 32'h0);
    chk("clock pin driven", {31'h0, sck_oe}, 32'h1);
    w[0] = 9'($urandom_range(255));
    partner.words.push_back(w[0]);
    wr(rs, 8'hA0);
    poll(pf, `SMR_BIT_RXFLAG);
    chk("irq raised", {31'h0, irq}, 32'h1);
    rc("single enable dropped", rs, 8'h80);
    rc("single word", rb, w[0][7:0]);
    rc("flag cleared", pf, 8'h00);
    repeat (200) @(posedge clk);
    rc("one word only", pf, 8'h00);
    chk("data released", {31'h0, doe}, 32'h0);
    chk("data line low", {31'h0, dout}, 32'h0);
    $display("test single done");
    nine = 1'b1;
    for (int i = 0; i < 4; i++) begin
      w[i] = 9'($urandom_range(511));
      partner.words.push_back(w[i]);
    end
    wr(rs, 8'hF0);
    poll(rs, `SMR_BIT_OVERRUN_ERROR);
    repeat (160) @(posedge clk);
    foreach (ictl[i]) begin
      wr(`SMR_IDX_INTCTL, ictl[i]);
      repeat (2) @(posedge clk);
      chk("irq gating", {31'h0, irq}, {31'h0, ictl[i] == 8'hC0});
    end
    wr(`SMR_IDX_PENABL, 8'h00);
    repeat (2) @(posedge clk);
    chk("irq enable off", {31'h0, irq}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      rc("status ninth", rs, {7'h79, w[i][8]});
      rc("fifo word", rb, w[i][7:0]);
    end
    // a word finishes with room in the fifo, and overrun must still keep it out
    repeat (160) @(posedge clk);
    rc("overrun blocks", pf, 8'h00);
    wr(rs, 8'hC0);
    rc("overrun cleared", rs, 8'hC0);
    partner.idx = 0;
    partner.words.delete();
    $display("test overrun done");
    nine = 1'b0;
    for (int i = 0; i < 3; i++) begin
      w[i] = 9'($urandom_range(255));
      partner.words.push_back(w[i]);
    end
    wr(rs, 8'h90);
    for (int i = 0; i < 3; i++) begin
      poll(pf, `SMR_BIT_RXFLAG);
      rc("stream word", rb, w[i][7:0]);
      if (i == 0) begin
        // forty cycles are five shift clock toggles, so a running clock would differ
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        hold = sck;
        repeat (40) @(posedge clk);
        chk("frozen clock", {31'h0, sck}, {31'h0, hold});
        ce <= 1'b1;
      end
    end
    wr(rs, 8'h80);
    $display("test stream done");
    tally_and_finish();
  end
endmodule
